// ---- logic/ecc_consts.svh ----
`ifndef ECC_CONSTS_SVH
`define ECC_CONSTS_SVH
`define ECC_CLK_MHZ 20
`define ECC_A_CFG 8'h00
`define ECC_A_SSI 8'h04
`define ECC_A_HWSEL 8'h08
`define ECC_A_LOAD 8'h0C
`define ECC_A_MIN 8'h10
`define ECC_A_MAX 8'h14
`define ECC_A_FILT0 8'h18
`define ECC_A_FILT1 8'h1C
`define ECC_A_CTRL 8'h20
`define ECC_A_COUNT 8'h24
`define ECC_A_POS 8'h28
`define ECC_A_STAT 8'h2C
`define ECC_CFG_RST 32'h0000_0000
`define ECC_SSI_RST 32'h0000_0018
`define ECC_HWSEL_RST 32'h0000_00B8
`define ECC_MIN_RST 32'h0000_0000
`define ECC_MAX_RST 32'h0000_7FFF
`define ECC_F_ENC 1:0
`define ECC_F_INTERP 3:2
`define ECC_F_CTYPE 5:4
`define ECC_F_SIZE32 6
`define ECC_F_DOWN 7
`define ECC_F_POL_A 8
`define ECC_F_POL_B 9
`define ECC_F_POL_N 10
`define ECC_F_RSRC 13:11
`define ECC_F_HSRC 16:14
`define ECC_F_RVAL 18:17
`define ECC_F_RLEVEL 19
`define ECC_F_LAPP 20
`define ECC_F_IRQEN 21
`define ECC_F_IRQSEL 23:22
`define ECC_F_CONT 24
`define ECC_F_ALONE 25
`define ECC_F_NOCHK 26
`define ECC_F_LEN25 0
`define ECC_F_RATE 2:1
`define ECC_F_MONO 4:3
`define ECC_F_SHR 5
`define ECC_F_SHIFT 9:6
`define ECC_F_LISTEN 10
`define ECC_F_HOLDIN 3:0
`define ECC_F_RSTIN 7:4
`define ECC_SSI_LEN_S 13
`define ECC_SSI_LEN_L 25
`define ECC_FLT5_US 5
`define ECC_FLT50_US 50
`define ECC_FLT1600_US 1600
`define ECC_QUAD_US 3
`define ECC_MONO_STEP_US 16
`define ECC_HALF125_NS 4000
`define ECC_HALF250_NS 2000
`define ECC_HALF500_NS 1000
`define ECC_HALF1M_NS 500
`define ECC_FLT5_CYC (`ECC_FLT5_US * `ECC_CLK_MHZ)
`define ECC_FLT50_CYC (`ECC_FLT50_US * `ECC_CLK_MHZ)
`define ECC_FLT1600_CYC (`ECC_FLT1600_US * `ECC_CLK_MHZ)
`define ECC_QUAD_CYC (`ECC_QUAD_US * `ECC_CLK_MHZ)
`define ECC_MONO_STEP_CYC (`ECC_MONO_STEP_US * `ECC_CLK_MHZ)
`define ECC_HALF125_CYC (`ECC_HALF125_NS * `ECC_CLK_MHZ / 1000)
`define ECC_HALF250_CYC (`ECC_HALF250_NS * `ECC_CLK_MHZ / 1000)
`define ECC_HALF500_CYC (`ECC_HALF500_NS * `ECC_CLK_MHZ / 1000)
`define ECC_HALF1M_CYC (`ECC_HALF1M_NS * `ECC_CLK_MHZ / 1000)
`endif

// ---- logic/ecc_pkg.sv ----
`default_nettype none
package ecc_pkg;
  typedef enum logic [1:0] {
    ENC_NONE = 2'b00, ENC_SSI = 2'b01, ENC_DIFF5 = 2'b10, ENC_SE24 = 2'b11
  } ecc_enc_t;
  typedef enum logic [1:0] {
    INT_PDIR = 2'b00, INT_X1 = 2'b01, INT_X2 = 2'b10, INT_X4 = 2'b11
  } ecc_interp_t;
  typedef enum logic [1:0] {
    CNT_CONT = 2'b00, CNT_PER = 2'b01, CNT_SINGLE = 2'b10
  } ecc_ctype_t;
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000, SRC_HW = 3'b001, SRC_SW = 3'b010,
    SRC_AND = 3'b011, SRC_OR = 3'b100
  } ecc_src_t;
  typedef enum logic [1:0] {
    RV_ZERO = 2'b00, RV_LIMIT = 2'b01, RV_LOAD = 2'b10
  } ecc_rval_t;
  typedef enum logic [1:0] {
    SSI_IDLE = 2'b00, SSI_SHIFT = 2'b01, SSI_MONO = 2'b10
  } ecc_ssi_st_t;
endpackage : ecc_pkg
`default_nettype wire

// ---- logic/ecc_encoder_counter.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ecc_consts.svh"
// Behaviour
// - encoder type none, SSI, 5V, 24V
// - SSI master 13/25 bits, four clock rates
// - monoflop 16..64 us before next frame
// - SSI word shifted left/right 0..12 bits
// - pulse/direction or x1/x2/x4 quadrature
// - counter 16/32 bit, three counting modes
// - programmable max limit, signed range defaults
// - reset/hold sources combined, reset edge or level
// - reset loads zero, limit or load value
// - main count direction up or down
// - A, B, N active level selectable
// - per-input delay filter, seven choices
// - interrupt enable and class selection
// - stand-alone halts unless permitted
// - host stop reaction stop or continue
// - unchecked mismatch keeps running
// - unchecked unparameterized keeps running
// - checked mismatch stops while host present
// - filter drops short bursts, delays pulses
// - quadrature inputs get 3 us delay at filter code 0, no delay at code 7
module ecc_encoder_counter #(
  parameter int FLT1600_CYC = `ECC_FLT1600_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [14:0] din,
  input  wire logic        enc_a,
  input  wire logic        enc_b,
  input  wire logic        enc_n,
  input  wire logic        ssi_data,
  input  wire logic        ssi_clk_in,
  output logic             ssi_clk_out,
  input  wire logic        host_present,
  input  wire logic        host_stopped,
  input  wire logic        param_match,
  input  wire logic        parameterized,
  input  wire logic [31:0] app_load_value,
  input  wire logic        diag_event,
  input  wire logic        proc_event,
  output logic      [31:0] count_value,
  output logic      [31:0] ssi_position,
  output logic             run_active,
  output logic             diag_irq,
  output logic             proc_irq
);
  import ecc_pkg::*;

  logic [31:0] cfg_reg, ssi_reg, hwsel_reg, load_reg, min_reg, max_reg;
  logic [53:0] filt_reg;
  logic [1:0]  ctrl_reg;
  logic        wr_pend_reg;
  logic [7:0]  addr_q_reg;
  logic [19:0] s1_reg, s2_reg;
  logic [17:0] filt_q;
  logic [31:0] cnt_reg;
  logic        done_reg;
  logic        a_d_reg, b_d_reg, rst_d_reg;
  ecc_ssi_st_t ssi_st_reg;
  logic [15:0] div_reg, mono_reg;
  logic [4:0]  bit_reg;
  logic [24:0] sh_reg, frame_reg;
  logic        frame_new_reg, lclk_d_reg;
  logic [31:0] rd_word;

  function automatic logic [15:0] flt_cyc(input logic [2:0] sel, input logic quad);
    case (sel)
      3'h0:    flt_cyc = quad ? 16'(`ECC_QUAD_CYC) : 16'h0000;
      3'h1,
      3'h2,
      3'h3,
      3'h4:    flt_cyc = 16'(sel) * 16'(`ECC_FLT5_CYC);
      3'h5:    flt_cyc = 16'(`ECC_FLT50_CYC);
      3'h6:    flt_cyc = 16'(FLT1600_CYC);
      default: flt_cyc = 16'h0000;
    endcase
  endfunction : flt_cyc

  function automatic logic src_comb(input logic [2:0] sel, input logic hw, input logic sw);
    case (sel)
      SRC_HW:  src_comb = hw;
      SRC_SW:  src_comb = sw;
      SRC_AND: src_comb = hw & sw;
      SRC_OR:  src_comb = hw | sw;
      default: src_comb = 1'b0;
    endcase
  endfunction : src_comb

  function automatic logic [31:0] sext(input logic [31:0] v, input logic w32);
    sext = w32 ? v : {{16{v[15]}}, v[15:0]};
  endfunction : sext

  // ---- AHB-Lite slave, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_q_reg  <= 8'h00;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
    end else begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= 1'b0;
      if (hready && hsel && htrans[1]) begin
        wr_pend_reg <= hwrite;
        addr_q_reg  <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_word;
        end
      end
    end
  end

  always_comb begin
    case (haddr[7:0])
      `ECC_A_CFG:   rd_word = cfg_reg;
      `ECC_A_SSI:   rd_word = ssi_reg;
      `ECC_A_HWSEL: rd_word = hwsel_reg;
      `ECC_A_LOAD:  rd_word = load_reg;
      `ECC_A_MIN:   rd_word = min_reg;
      `ECC_A_MAX:   rd_word = max_reg;
      `ECC_A_FILT0: rd_word = {2'b00, filt_reg[29:0]};
      `ECC_A_FILT1: rd_word = {8'h00, filt_reg[53:30]};
      `ECC_A_CTRL:  rd_word = {30'h0000_0000, ctrl_reg};
      `ECC_A_COUNT: rd_word = cnt_reg;
      `ECC_A_POS:   rd_word = ssi_position;
      `ECC_A_STAT:  rd_word = {27'h000_0000, filt_q[17] ~^ cfg_reg[`ECC_F_POL_N],
                             done_reg, ssi_st_reg != SSI_IDLE, run_active, frame_new_reg};
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  // writes land in the data phase; registers are static config
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg   <= `ECC_CFG_RST;
      ssi_reg   <= `ECC_SSI_RST;
      hwsel_reg <= `ECC_HWSEL_RST;
      load_reg  <= 32'h0000_0000;
      min_reg   <= `ECC_MIN_RST;
      max_reg   <= `ECC_MAX_RST;
      filt_reg  <= '0;
      ctrl_reg  <= 2'b00;
    end else if (wr_pend_reg) begin
      case (addr_q_reg)
        `ECC_A_CFG:   cfg_reg   <= {5'h00, hwdata[26:0]};
        `ECC_A_SSI:   ssi_reg   <= {21'h00_0000, hwdata[10:0]};
        `ECC_A_HWSEL: hwsel_reg <= {24'h00_0000, hwdata[7:0]};
        `ECC_A_LOAD:  load_reg  <= hwdata;
        `ECC_A_MIN:   min_reg   <= hwdata;
        `ECC_A_MAX:   max_reg   <= hwdata;
        `ECC_A_FILT0: filt_reg[29:0]  <= hwdata[29:0];
        `ECC_A_FILT1: filt_reg[53:30] <= hwdata[23:0];
        `ECC_A_CTRL:  ctrl_reg  <= hwdata[1:0];
        default:      ;
      endcase
    end
  end

  // ---- pin synchronisers: din, A, B, N, SSI data, SSI clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= {ssi_clk_in, ssi_data, enc_n, enc_b, enc_a, din};
      s2_reg <= s1_reg;
    end
  end

  // ---- delay filters: output follows only after input stood thr cycles
  genvar gi;
  generate
    for (gi = 0; gi < 18; gi++) begin : g_flt
      logic [15:0] cnt_f_reg;
      logic [15:0] thr;
      logic        q_reg;
      // one process per bit, so each flop owns its own variable
      assign filt_q[gi] = q_reg;
      assign thr = flt_cyc(filt_reg[3*gi +: 3], gi >= 15);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_f_reg <= 16'h0000;
          q_reg     <= 1'b0;
        end else if (s2_reg[gi] == q_reg) begin
          cnt_f_reg <= 16'h0000;
        end else if (cnt_f_reg + 16'h0001 >= thr) begin
          cnt_f_reg <= 16'h0000;
          q_reg     <= s2_reg[gi];
        end else begin
          cnt_f_reg <= cnt_f_reg + 16'h0001;
        end
      end
    end
  endgenerate

  // ---- run / stop supervision
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_active <= 1'b0;
    end else if (!host_present) begin
      run_active <= cfg_reg[`ECC_F_ALONE];
    end else begin
      run_active <= (!host_stopped || cfg_reg[`ECC_F_CONT]) &&
                    (cfg_reg[`ECC_F_NOCHK] ||
                     (param_match && parameterized));
    end
  end

  // ---- interrupt class gating, events come from module logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      diag_irq <= 1'b0;
      proc_irq <= 1'b0;
    end else begin
      diag_irq <= cfg_reg[`ECC_F_IRQEN] & cfg_reg[22] & diag_event;
      proc_irq <= cfg_reg[`ECC_F_IRQEN] & cfg_reg[23] & proc_event;
    end
  end

  // ---- SSI engine
  logic [15:0] half_cyc, mono_cyc;
  logic [4:0]  frame_len;
  logic        ssi_on, listen, lclk_rise;
  logic [24:0] sh_in;
  always_comb begin
    case (ssi_reg[`ECC_F_RATE])
      2'h0:    half_cyc = 16'(`ECC_HALF125_CYC);
      2'h1:    half_cyc = 16'(`ECC_HALF250_CYC);
      2'h2:    half_cyc = 16'(`ECC_HALF500_CYC);
      default: half_cyc = 16'(`ECC_HALF1M_CYC);
    endcase
  end
  assign mono_cyc  = (16'(ssi_reg[`ECC_F_MONO]) + 16'h0001) * 16'(`ECC_MONO_STEP_CYC);
  assign frame_len = ssi_reg[`ECC_F_LEN25] ? 5'(`ECC_SSI_LEN_L) : 5'(`ECC_SSI_LEN_S);
  assign ssi_on    = run_active && (cfg_reg[`ECC_F_ENC] == ENC_SSI);
  assign listen    = ssi_reg[`ECC_F_LISTEN];
  assign lclk_rise = s2_reg[19] & ~lclk_d_reg;
  // first bit of a frame clears stale bits of a longer previous frame
  assign sh_in = (bit_reg == 5'h00) ? {24'h00_0000, s2_reg[18]} : {sh_reg[23:0], s2_reg[18]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ssi_st_reg    <= SSI_IDLE;
      ssi_clk_out   <= 1'b1;
      div_reg       <= 16'h0000;
      mono_reg      <= 16'h0000;
      bit_reg       <= 5'h00;
      sh_reg        <= '0;
      frame_reg     <= '0;
      frame_new_reg <= 1'b0;
      lclk_d_reg    <= 1'b0;
    end else begin
      frame_new_reg <= 1'b0;
      lclk_d_reg    <= s2_reg[19];
      if (!ssi_on) begin
        ssi_st_reg  <= SSI_IDLE;
        ssi_clk_out <= 1'b1;
        bit_reg     <= 5'h00;
        mono_reg    <= 16'h0000;
      end else if (listen) begin
        // listen: only sample the other master's clock
        ssi_clk_out <= 1'b1;
        ssi_st_reg  <= SSI_IDLE;
        if (lclk_rise) begin
          mono_reg <= 16'h0000;
          sh_reg   <= sh_in;
          if (bit_reg + 5'h01 == frame_len) begin
            bit_reg       <= 5'h00;
            frame_reg     <= sh_in;
            frame_new_reg <= 1'b1;
          end else begin
            bit_reg <= bit_reg + 5'h01;
          end
        end else if (mono_reg >= mono_cyc) begin
          bit_reg <= 5'h00; // resync after a pause
        end else begin
          mono_reg <= mono_reg + 16'h0001;
        end
      end else begin
        case (ssi_st_reg)
          SSI_IDLE: begin
            ssi_clk_out <= 1'b0;
            div_reg     <= 16'h0000;
            bit_reg     <= 5'h00;
            ssi_st_reg  <= SSI_SHIFT;
          end
          SSI_SHIFT: begin
            if (div_reg + 16'h0001 >= half_cyc) begin
              div_reg     <= 16'h0000;
              ssi_clk_out <= ~ssi_clk_out;
              if (!ssi_clk_out) begin
                sh_reg <= sh_in;
                if (bit_reg + 5'h01 == frame_len) begin
                  frame_reg     <= sh_in;
                  frame_new_reg <= 1'b1;
                  mono_reg      <= 16'h0000;
                  ssi_st_reg    <= SSI_MONO;
                end else begin
                  bit_reg <= bit_reg + 5'h01;
                end
              end
            end else begin
              div_reg <= div_reg + 16'h0001;
            end
          end
          SSI_MONO: begin
            if (mono_reg + 16'h0001 >= mono_cyc) begin
              ssi_st_reg <= SSI_IDLE;
            end else begin
              mono_reg <= mono_reg + 16'h0001;
            end
          end
          default: ssi_st_reg <= SSI_IDLE;
        endcase
      end
    end
  end

  // shift amounts above 12 are not meaningful and not clamped
  logic [31:0] frame_ext;
  assign frame_ext = {7'h00, frame_reg};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ssi_position <= 32'h0000_0000;
    end else if (frame_new_reg) begin
      ssi_position <= ssi_reg[`ECC_F_SHR] ? frame_ext >> ssi_reg[`ECC_F_SHIFT]
                                           : frame_ext << ssi_reg[`ECC_F_SHIFT];
    end
  end

  // ---- incremental counter
  logic        a_act, b_act, a_edge, b_edge, a_rise, step, up, w32;
  logic        hw_rst, hw_hold, rst_lvl, rst_now, hold_now, at_hi, at_lo, cnt_on;
  logic [31:0] lo, hi, rst_val, load_v;
  assign a_act  = cfg_reg[`ECC_F_POL_A] ? filt_q[15] : ~filt_q[15];
  assign b_act  = cfg_reg[`ECC_F_POL_B] ? filt_q[16] : ~filt_q[16];
  assign a_edge = a_act ^ a_d_reg;
  assign b_edge = b_act ^ b_d_reg;
  assign a_rise = a_act & ~a_d_reg;
  assign w32    = cfg_reg[`ECC_F_SIZE32];

  always_comb begin
    case (cfg_reg[`ECC_F_INTERP])
      INT_X1: begin
        step = a_rise;
        up   = ~b_act;
      end
      INT_X2: begin
        step = a_edge;
        up   = a_act ^ b_act;
      end
      INT_X4: begin
        step = a_edge ^ b_edge;
        up   = a_edge ? (a_act ^ b_act) : ~(a_act ^ b_act);
      end
      default: begin
        step = a_rise;
        up   = ~b_act;
      end
    endcase
    up = up ^ cfg_reg[`ECC_F_DOWN];
  end

  always_comb begin
    if (cfg_reg[`ECC_F_CTYPE] == CNT_CONT) begin
      lo = w32 ? 32'h8000_0000 : 32'hFFFF_8000;
      hi = w32 ? 32'h7FFF_FFFF : 32'h0000_7FFF;
    end else begin
      lo = sext(min_reg, w32);
      hi = sext(max_reg, w32);
    end
  end

  assign hw_rst   = (hwsel_reg[`ECC_F_RSTIN] < 4'hF) ? filt_q[hwsel_reg[`ECC_F_RSTIN]] : 1'b0;
  assign hw_hold  = (hwsel_reg[`ECC_F_HOLDIN] < 4'hF) ? filt_q[hwsel_reg[`ECC_F_HOLDIN]] : 1'b0;
  assign rst_lvl  = src_comb(cfg_reg[`ECC_F_RSRC], hw_rst, ctrl_reg[0]);
  assign rst_now  = cfg_reg[`ECC_F_RLEVEL] ? rst_lvl : (rst_lvl & ~rst_d_reg);
  assign hold_now = src_comb(cfg_reg[`ECC_F_HSRC], hw_hold, ctrl_reg[1]);
  assign load_v   = cfg_reg[`ECC_F_LAPP] ? app_load_value : load_reg;
  assign at_hi    = (cnt_reg == hi);
  assign at_lo    = (cnt_reg == lo);
  assign cnt_on   = run_active && cfg_reg[1];

  always_comb begin
    case (cfg_reg[`ECC_F_RVAL])
      RV_LIMIT: rst_val = cfg_reg[`ECC_F_DOWN] ? hi : lo;
      RV_LOAD:  rst_val = sext(load_v, w32);
      default:  rst_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_d_reg   <= 1'b0;
      b_d_reg   <= 1'b0;
      rst_d_reg <= 1'b0;
    end else begin
      a_d_reg   <= a_act;
      b_d_reg   <= b_act;
      rst_d_reg <= rst_lvl;
    end
  end

  // reset wins over counting; single mode parks at the limit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg  <= 32'h0000_0000;
      done_reg <= 1'b0;
    end else if (rst_now) begin
      cnt_reg  <= rst_val;
      done_reg <= 1'b0;
    end else if (cnt_on && step && !hold_now && !done_reg) begin
      if (up ? at_hi : at_lo) begin
        if (cfg_reg[`ECC_F_CTYPE] == CNT_SINGLE) begin
          done_reg <= 1'b1;
        end else begin
          cnt_reg <= up ? lo : hi;
        end
      end else begin
        cnt_reg <= sext(up ? cnt_reg + 32'h0000_0001 : cnt_reg - 32'h0000_0001, w32);
      end
    end
  end

  assign count_value = cnt_reg;

endmodule : ecc_encoder_counter
`default_nettype wire

// ---- bench/ecc_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module ecc_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        ssi_clk_out,
  input wire logic        run_active,
  input wire logic        diag_event,
  input wire logic        proc_event,
  input wire logic [31:0] ssi_position,
  input wire logic        diag_irq,
  input wire logic        proc_irq
);
  logic [10:0] hi_cnt;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // starts saturated so the first frame after reset never looks early
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hi_cnt <= 11'h7FF;
    else if (!ssi_clk_out) hi_cnt <= 11'h000;
    else if (hi_cnt != 11'h7FF) hi_cnt <= hi_cnt + 11'h001;
  end
  a_resp_okay: assert property (hresp == 1'b0) else $error("bad resp");
  a_rd_stable: assert property ($changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
    else $error("read data moved");
  a_diag_cause: assert property (diag_irq |-> $past(diag_event)) else $error("diag irq");
  a_proc_cause: assert property (proc_irq |-> $past(proc_event)) else $error("proc irq");
  a_clk_idle: assert property ((!run_active)[*3] |-> ssi_clk_out) else $error("clk idle");
  a_frame_run: assert property ($fell(ssi_clk_out) |-> $past(run_active)) else $error("run");
  a_low_min: assert property ($fell(ssi_clk_out) |-> (!ssi_clk_out)[*8]) else $error("low");
  a_low_max: assert property ($fell(ssi_clk_out) |-> ##[1:80] ssi_clk_out) else $error("low");
  a_mono_gap: assert property ($fell(ssi_clk_out) |-> hi_cnt <= 11'h05A || hi_cnt >= 11'h12C)
    else $error("early frame");
  a_pos_frame: assert property ($changed(ssi_position) |-> ssi_clk_out) else $error("pos");
endmodule : ecc_checker
bind ecc_encoder_counter ecc_checker u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hrdata, .hresp, .ssi_clk_out, .run_active, .diag_event, .proc_event, .ssi_position, .diag_irq,
  .proc_irq);
`default_nettype wire

// ---- bench/ecc_ssi_enc_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ecc_ssi_enc_model #(
  parameter int DLY_NS   = 100,
  parameter int IDLE_CYC = 200
) (
  input  wire logic        hclk,
  input  wire logic        sclk,
  input  wire logic [31:0] pos,
  input  wire logic        len25,
  output logic             sdata,
  output int               frames
);
  int          idx = -1;
  int          hi = 0;
  logic [31:0] word;
  initial sdata = 1'b1;
  initial frames = 0;
  // word latched at the first falling edge, msb first
  always @(negedge sclk) begin
    if (idx < 0) begin
      word = pos;
      idx = len25 ? 24 : 12;
    end else if (idx > 0) idx = idx - 1;
    sdata <= #DLY_NS word[idx];
  end
  // low after the lsb until the delay runs out
  always @(posedge sclk) if (idx == 0) sdata <= #DLY_NS 1'b0;
  // a new frame is only accepted after a long idle clock
  always @(posedge hclk) begin
    hi = sclk ? hi + 1 : 0;
    if (hi == IDLE_CYC && idx >= 0) begin
      idx = -1;
      sdata <= 1'b1;
      frames = frames + 1;
    end
  end
endmodule : ecc_ssi_enc_model
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ecc_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t %h %h", $time, (g), (e)); end end
module testbench;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, enc_a = 1'b0;
  logic        enc_b = 1'b0, lk = 1'b1, listen = 1'b0, present = 1'b1, stopped = 1'b0;
  logic        match = 1'b1, param = 1'b1, dev = 1'b0, pev = 1'b0, len25 = 1'b0, b;
  logic [1:0]  htrans = 2'h0;
  logic [14:0] din = 15'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, pos = 32'h0, rd, e, v, cf;
  wire logic [31:0] hrdata, count_value, ssi_position;
  wire logic   hreadyout, ssi_clk_out, run_active, diag_irq, proc_irq, sdata, sclk;
  int          mismatches = 0, cmp_count = 0, cyc = 0, hic = 0, gap = 0, frames;
  int          seed = 32'h02e2f47c;
  assign sclk = listen ? lk : ssi_clk_out;
  ecc_encoder_counter #(.FLT1600_CYC(400)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .din(din),
    .enc_a(enc_a), .enc_b(enc_b), .enc_n(1'b0), .ssi_data(sdata), .ssi_clk_in(lk),
    .ssi_clk_out(ssi_clk_out), .host_present(present), .host_stopped(stopped),
    .param_match(match), .parameterized(param), .app_load_value(32'h0), .diag_event(dev),
    .proc_event(pev), .count_value(count_value), .ssi_position(ssi_position),
    .run_active(run_active), .diag_irq(diag_irq), .proc_irq(proc_irq));
  ecc_ssi_enc_model u_enc (.hclk(hclk), .sclk(sclk), .pos(pos), .len25(len25), .sdata(sdata),
    .frames(frames));
  task automatic results;
    if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  // each phase outlasts the fixed 60-cycle input delay
  task automatic quad(input int n, input int md);
    repeat (n) for (int s = 1; s < 5; s++) begin
      enc_a <= s % 4 == 1 || s % 4 == 2;
      enc_b <= md != 0 && s % 4 >= 2;
      tick(80);
    end
    tick(40);
  endtask : quad
  task automatic pulse(input int w);
    din <= 15'h0008;
    tick(w);
    din <= 15'h0;
    tick(700);
  endtask : pulse
  always #25 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (ssi_clk_out) hic++;
    else begin
      if (hic > 200) gap = hic;
      hic = 0;
    end
    if (cyc == 80000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    int i, r, f0, sh;
    int m[5] = '{0, 1, 2, 3, 3};
    int kk[4] = '{1, 1, 2, 4};
    logic [7:0] ra[8] = '{`ECC_A_CFG, `ECC_A_SSI, `ECC_A_HWSEL, `ECC_A_LOAD, `ECC_A_MIN,
      `ECC_A_MAX, `ECC_A_CTRL, 8'h30};
    logic [31:0] rv[8] = '{`ECC_CFG_RST, `ECC_SSI_RST, `ECC_HWSEL_RST, 32'h0, `ECC_MIN_RST,
      `ECC_MAX_RST, 32'h0, 32'h0};
    tick(6);
    hresetn <= 1'b1;
    for (i = 0; i < 8; i++) begin
      bus(1'b0, ra[i], 32'h0);
      `CHK(rd, rv[i])
    end
    for (i = 0; i < 12; i++) begin
      r = $random(seed);
      b = r[5] | r[6];
      present <= b;
      stopped <= r[2];
      match <= r[3] | !b;
      param <= r[4] | !b;
      bus(1'b1, `ECC_A_CFG, {5'h0, r[1], r[7], r[0], 24'h0});
      b = b ? (!r[2] | r[0]) & (r[1] | (r[3] & r[4])) : r[7];
      tick(3);
      `CHK(run_active, b)
    end
    {present, stopped, match, param} <= 4'hB;
    for (i = 0; i < 5; i++) begin
      bus(1'b1, `ECC_A_CFG, {8'h0, i[1:0], i < 4, 21'h0});
      {dev, pev} <= 2'h3;
      @(posedge hclk);
      {dev, pev} <= 2'h0;
      @(negedge hclk);
      `CHK(diag_irq, i < 4 && i[0])
      `CHK(proc_irq, i < 4 && i[1])
    end
    for (i = 0; i < 5; i++) begin
      cf = {15'h0, 3'h2, 3'h2, 3'h3, i == 4, i == 2, 2'h0, 2'(m[i]), (i == 0) ? 2'h3 : 2'h2};
      bus(1'b1, `ECC_A_CFG, cf);
      bus(1'b1, `ECC_A_CTRL, 32'h1);
      bus(1'b1, `ECC_A_CTRL, 32'h0);
      quad(3, m[i]);
      e = (i == 4) ? -3 * kk[m[i]] : 3 * kk[m[i]];
      bus(1'b0, `ECC_A_COUNT, 32'h0);
      `CHK(rd, e)
      `CHK(count_value, e)
    end
    bus(1'b1, `ECC_A_CTRL, 32'h2);
    quad(1, 3);
    `CHK(count_value, e)
    bus(1'b1, `ECC_A_CFG, {15'h0, 3'h0, 3'h1, 3'h3, 4'h0, 2'h3, 2'h2});
    bus(1'b1, `ECC_A_HWSEL, 32'h3F);
    for (i = 0; i < 2; i++) begin
      bus(1'b1, `ECC_A_FILT0, i ? 32'h0C00 : 32'h0200);
      quad(1, 3);
      e = e + 4;
      pulse(i ? 300 : 80);
      `CHK(count_value, e)
      pulse(i ? 500 : 140);
      `CHK(count_value, 32'h0)
      e = 32'h0;
    end
    bus(1'b1, `ECC_A_CFG, 32'h1);
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      sh = r[31:28] % 13;
      len25 <= i[0];
      pos <= $random(seed);
      bus(1'b1, `ECC_A_SSI, {22'h0, 4'(sh), r[0], 2'(3 - i), 2'(i), i[0]});
      f0 = frames;
      wait (frames >= f0 + 2);
      v = pos & (i[0] ? 32'h01FF_FFFF : 32'h0000_1FFF);
      e = r[0] ? v >> sh : v << sh;
      `CHK(ssi_position, e)
      @(negedge ssi_clk_out);
      tick(2);
      f0 = (4 - i) * `ECC_MONO_STEP_CYC;
      b = gap >= f0 && gap <= f0 + (`ECC_HALF125_CYC >> i) * 2 + 8;
      `CHK(b, 1'b1)
    end
    listen <= 1'b1;
    len25 <= 1'b0;
    pos <= $random(seed);
    bus(1'b1, `ECC_A_SSI, 32'h400);
    tick(600);
    f0 = frames;
    #37;
    repeat (13) begin
      lk = 1'b0;
      #200;
      lk = 1'b1;
      #200;
    end
    wait (frames >= f0 + 1);
    `CHK(ssi_position, pos & 32'h1FFF)
    results();
  end
endmodule : testbench
`default_nettype wire
